//--- dv/comparator_gpio_pin_mux_sva.sv
// port assertions for the auxiliary pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module comparator_gpio_pin_mux_sva (
    // clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rst_n,
    // bus and pins
    input wire pin_mux_pkg::apb_req_t   apb_req,
    input wire logic                    apb_from_ctrl_cpu,
    input wire pin_mux_pkg::apb_rsp_t   apb_rsp,
    input wire pin_mux_pkg::pin_drive_t aux_pin_drive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic stp;
    logic wr;
    assign stp = apb_req.psel && !apb_req.penable;
    assign wr  = stp && apb_req.pwrite && apb_from_ctrl_cpu;
    // pins follow a register write three edges after its setup
    property p_rdy; stp |=> apb_rsp.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; stp && !apb_from_ctrl_cpu |=> apb_rsp.pslverr; endproperty
    a_err: assert property (p_err) else $error("foreign master accepted");
    property p_zero; !apb_rsp.pready |-> apb_rsp.prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("read data outside answer");
    property p_pud;
        wr && apb_req.paddr == 12'h004 |-> ##3
            aux_pin_drive.pullup_en == ~$past(apb_req.pwdata[7:0], 3);
    endproperty
    a_pud: assert property (p_pud) else $error("pullup not per register");
    property p_ign;
        stp && apb_req.pwrite && !apb_from_ctrl_cpu |-> ##3 $stable(aux_pin_drive.pullup_en);
    endproperty
    a_ign: assert property (p_ign) else $error("foreign write changed pullup");
    property p_m3; wr && apb_req.paddr == 12'h000 && apb_req.pwdata[5:4] == 2'h3
        |-> ##3 aux_pin_drive.enable[2]; endproperty
    a_m3: assert property (p_m3) else $error("pin 2 comparator not driven");
    property p_rsv; wr && apb_req.paddr == 12'h000 && (apb_req.pwdata[5] != apb_req.pwdata[4])
        |-> ##3 !aux_pin_drive.enable[2]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved mode drives pin 2");
    property p_p0; wr && apb_req.paddr == 12'h000 && apb_req.pwdata[1:0] == 2'h3
        |-> ##3 !aux_pin_drive.enable[0]; endproperty
    a_p0: assert property (p_p0) else $error("pin 0 driven in mode 3");
    c_err: cover property (stp && !apb_from_ctrl_cpu);
    c_m3: cover property (wr && apb_req.paddr == 12'h000 && apb_req.pwdata[5:4] == 2'h3);
    c_rsv: cover property (wr && apb_req.paddr == 12'h000 && apb_req.pwdata[5:4] == 2'h1);
endmodule : comparator_gpio_pin_mux_sva
`default_nettype wire

//--- dv/comparator_gpio_pin_mux_tb_top.sv
// self-checking bench for the auxiliary pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module comparator_gpio_pin_mux_tb_top;
    logic                    sys_clk = 1'b0;
    logic                    rst_n   = 1'b0;
    pin_mux_pkg::apb_req_t   req     = '0;
    logic                    ctrl    = 1'b0;
    pin_mux_pkg::apb_rsp_t   rsp;
    logic [7:0]              pin_in  = 8'h00;
    logic [5:0]              comp    = 6'h00;
    pin_mux_pkg::pin_drive_t drv;
    logic [31:0]             rdv;
    logic                    erv;
    int                      num_errors = 0;
    int                      tests_run  = 0;
    int                      seed       = 32'h97750f53;
    always #2 sys_clk = ~sys_clk;
    comparator_gpio_pin_mux uut (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req),
        .apb_from_ctrl_cpu(ctrl), .apb_rsp(rsp), .aux_pin_in(pin_in),
        .comparator_result(comp), .aux_pin_drive(drv));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] cmap(input int p);
        logic [2:0] t [8] = '{3'h0, 3'h1, 3'h6, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5};
        return t[p];
    endfunction : cmap
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // only the watchdog ends a wait for ready, so a dead slave still reaches the verdict
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
        @(posedge sys_clk);
        req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= w; req.paddr <= a;
        req.pwdata <= d; ctrl <= c;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (rsp.pready !== 1'b1);
        rdv = rsp.prdata; erv = rsp.pslverr;
        req.psel <= 1'b0; req.penable <= 1'b0;
    endtask : xfer
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin #200000; num_errors++; summarize(); end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
        logic [31:0] rv [5] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0};
        logic [8:0]  qk [5] = '{9'h02c, 9'h0b0, 9'h028, 9'h1bf, 9'h136};
        logic [31:0] qe [5] = '{32'h0, 32'h100 | pin_mux_pkg::FN_CAPTURE_5,
            32'h100 | pin_mux_pkg::FN_GPIO, 32'h100 | pin_mux_pkg::FN_PWM9_B, 32'h100};
        logic [31:0] d;
        logic [31:0] sh [5];
        logic [31:0] mk;
        logic [15:0] sel;
        logic [1:0]  m;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk("enable", {24'h0, drv.enable}, 32'h0);
        chk("pullup", {24'h0, drv.pullup_en}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, ra[i], 32'h0, 1'b1);
            chk("reset value", rdv, rv[i]);
        end
        $display("test reset done");
        // shadow of what was written; pins are low, so data reads back latch and direction
        sh = rv;
        for (int i = 0; i < 10; i++) begin
            d = $random(seed);
            mk = (i % 5 == 0) ? 32'hffff : 32'hff;
            sh[i % 5] = d & mk;
            xfer(1'b1, ra[i % 5], d, 1'b1);
            xfer(1'b0, ra[i % 5], 32'h0, 1'b1);
            chk("readback", rdv, (i % 5 == 2) ? (sh[2] & sh[3]) : sh[i % 5]);
            if (i % 5 == 1) chk("pullup", {24'h0, drv.pullup_en}, {24'h0, ~d[7:0]});
        end
        xfer(1'b1, 12'h004, 32'h0, 1'b0);
        chk("foreign error", {31'h0, erv}, 32'h1);
        xfer(1'b0, 12'h004, 32'h0, 1'b1);
        chk("foreign write", rdv, sh[1]);
        xfer(1'b0, 12'h020, 32'h0, 1'b1);
        chk("unmapped", {rdv[30:0], erv}, 32'h1);
        $display("test register access done");
        xfer(1'b1, 12'h00c, 32'hff, 1'b1);
        xfer(1'b1, 12'h010, 32'hff, 1'b1);
        for (int k = 0; k < 10; k++) begin
            m = k[1:0];
            sel = (k < 4) ? {8{m}} : 16'($random(seed));
            d = $random(seed);
            xfer(1'b1, 12'h008, d, 1'b1);
            comp <= 6'($random(seed));
            xfer(1'b1, 12'h000, {16'h0, sel}, 1'b1);
            repeat (10) @(posedge sys_clk);
            for (int p = 0; p < 8; p++) begin
                m = sel[2*p +: 2];
                chk("pin enable", {31'h0, drv.enable[p]},
                    {31'h0, m == 2'h0 || (m == 2'h3 && cmap(p) != 3'h0)});
                if (m == 2'h0) chk("gpio level", {31'h0, drv.level[p]}, {31'h0, d[p]});
                if (m == 2'h3 && cmap(p) != 3'h0)
                    chk("comp level", {31'h0, drv.level[p]}, {31'h0, comp[cmap(p) - 1]});
            end
        end
        $display("test pin select done");
        xfer(1'b1, 12'h00c, 32'h0, 1'b1);
        pin_in <= 8'($random(seed));
        repeat (10) @(posedge sys_clk);
        xfer(1'b0, 12'h008, 32'h0, 1'b1);
        chk("input data", rdv, {24'h0, pin_in});
        xfer(1'b0, 12'h014, 32'h0, 1'b1);
        chk("pin level", rdv, {24'h0, pin_in});
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, 12'h018, {22'h0, qk[i][8:7], 1'b0, qk[i][6:0]}, 1'b1);
            xfer(1'b0, 12'h01c, 32'h0, 1'b1);
            chk("main table", rdv, qe[i]);
        end
        $display("test inputs and main table done");
        summarize();
    end
endmodule : comparator_gpio_pin_mux_tb_top
bind comparator_gpio_pin_mux comparator_gpio_pin_mux_sva chk_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .apb_req(apb_req), .apb_from_ctrl_cpu(apb_from_ctrl_cpu),
    .apb_rsp(apb_rsp), .aux_pin_drive(aux_pin_drive));
`default_nettype wire

//--- logic/comparator_gpio_pin_mux.sv
// auxiliary eight-pin bank: gpio or comparator output per pin, apb registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"

module comparator_gpio_pin_mux (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // register bus
    input  wire pin_mux_pkg::apb_req_t      apb_req,
    input  wire logic                       apb_from_ctrl_cpu,
    output var  pin_mux_pkg::apb_rsp_t      apb_rsp,
    // pins and comparator results
    input  wire logic [`AUX_PIN_COUNT-1:0]  aux_pin_in,
    input  wire logic [`AUX_COMP_COUNT-1:0] comparator_result,
    output var  pin_mux_pkg::pin_drive_t    aux_pin_drive
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [`AUX_SEL_W-1:0]      pin_select_r;
    logic [`AUX_SEL_W-1:0]      pin_select_nxt;
    logic [`AUX_PIN_COUNT-1:0]  pullup_dis_r;
    logic [`AUX_PIN_COUNT-1:0]  pullup_dis_nxt;
    logic [`AUX_PIN_COUNT-1:0]  data_r;
    logic [`AUX_PIN_COUNT-1:0]  data_nxt;
    logic [`AUX_PIN_COUNT-1:0]  dir_r;
    logic [`AUX_PIN_COUNT-1:0]  dir_nxt;
    logic [`AUX_PIN_COUNT-1:0]  gpio_en_r;
    logic [`AUX_PIN_COUNT-1:0]  gpio_en_nxt;
    logic [`QUERY_W-1:0]        main_query_r;
    logic [`QUERY_W-1:0]        main_query_nxt;
    logic [`APB_DATA_W-1:0]     main_result_r;
    logic [`APB_DATA_W-1:0]     main_result_nxt;

    logic [`APB_DATA_W-1:0]     prdata_r;
    logic [`APB_DATA_W-1:0]     prdata_nxt;
    logic                       pready_r;
    logic                       pready_nxt;
    logic                       pslverr_r;
    logic                       pslverr_nxt;

    pin_mux_pkg::pin_drive_t    drive_r;
    pin_mux_pkg::pin_drive_t    drive_nxt;

    logic [`AUX_PIN_COUNT-1:0]  pin_level;
    logic [`AUX_COMP_COUNT-1:0] comp_level;
    pin_mux_pkg::main_func_t    table_func;
    logic                       table_present;

    logic                       apb_setup;
    logic                       apb_write;
    logic [`APB_ADDR_W-1:0]     addr;
    logic [`APB_DATA_W-1:0]     wdata;
    logic [`AUX_PIN_COUNT-1:0]  data_view;
    pin_mux_pkg::aux_mode_t     mode_n;
    logic [`COMP_IDX_W-1:0]     comp_src_n;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // comparator number routed to a pin in mode 3, zero when none
    function automatic logic [`COMP_IDX_W-1:0] comp_source(input int pin);
        unique case (pin)
            1:       comp_source = 3'h1;
            2:       comp_source = 3'h6;
            3:       comp_source = 3'h2;
            4:       comp_source = 3'h3;
            5:       comp_source = 3'h4;
            7:       comp_source = 3'h5;
            default: comp_source = `COMP_NONE;
        endcase
    endfunction : comp_source

    // two-bit mode field of one pin
    function automatic pin_mux_pkg::aux_mode_t pin_mode(
        input logic [`AUX_SEL_W-1:0] sel,
        input int                    pin
    );
        pin_mode = pin_mux_pkg::aux_mode_t'(sel[2*pin +: 2]);
    endfunction : pin_mode

    // address decode for the error path; reads decode the address in their own case
    function automatic logic addr_mapped(input logic [`APB_ADDR_W-1:0] a);
        unique case (a)
            `OFS_PIN_SELECT, `OFS_PULLUP_DIS, `OFS_DATA, `OFS_DIR,
            `OFS_GPIO_EN, `OFS_PIN_LEVEL, `OFS_MAIN_QUERY,
            `OFS_MAIN_RESULT: addr_mapped = 1'b1;
            default:          addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    level_sync3 #(
        .WIDTH (`AUX_PIN_COUNT)
    ) u_pin_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .async_in  (aux_pin_in),
        .level_out (pin_level)
    );

    // comparators run asynchronously to the bus clock
    level_sync3 #(
        .WIDTH (`AUX_COMP_COUNT)
    ) u_comp_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .async_in  (comparator_result),
        .level_out (comp_level)
    );

    // ----------------------------------------------------------------
    // main bank lookup
    // ----------------------------------------------------------------
    // main bank table
    main_bank_func_table u_main_table (
        .pin_num (main_query_r[`QUERY_PIN_MSB:`QUERY_PIN_LSB]),
        .mode    (pin_mux_pkg::aux_mode_t'(main_query_r[`QUERY_MODE_MSB:`QUERY_MODE_LSB])),
        .func    (table_func),
        .present (table_present)
    );

    always_comb begin
        main_result_nxt = '0;
        main_result_nxt[`RESULT_FUNC_MSB:0] = table_func;
        main_result_nxt[`RESULT_PRESENT_BIT] = table_present;
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign addr      = apb_req.paddr;
    assign wdata     = apb_req.pwdata;
    assign apb_setup = apb_req.psel && !apb_req.penable;
    // foreign masters are flagged at setup and never write
    assign apb_write = apb_req.psel && apb_req.penable && pready_r
                       && apb_req.pwrite && !pslverr_r;

    // data reads show the latch for outputs and the pin for inputs
    assign data_view = (dir_r & data_r) | (~dir_r & pin_level);

    // answer is prepared in setup so the access phase always lasts one cycle
    always_comb begin
        pready_nxt  = apb_setup;
        pslverr_nxt = 1'b0;
        prdata_nxt  = '0;
        if (apb_setup) begin
            // other masters get an error and read zero
            pslverr_nxt = !apb_from_ctrl_cpu || !addr_mapped(addr);
            if (apb_from_ctrl_cpu && !apb_req.pwrite) begin
                unique case (addr)
                    `OFS_PIN_SELECT:  prdata_nxt[`AUX_SEL_W-1:0]     = pin_select_r;
                    `OFS_PULLUP_DIS:  prdata_nxt[`AUX_PIN_COUNT-1:0] = pullup_dis_r;
                    `OFS_DATA:        prdata_nxt[`AUX_PIN_COUNT-1:0] = data_view;
                    `OFS_DIR:         prdata_nxt[`AUX_PIN_COUNT-1:0] = dir_r;
                    `OFS_GPIO_EN:     prdata_nxt[`AUX_PIN_COUNT-1:0] = gpio_en_r;
                    `OFS_PIN_LEVEL:   prdata_nxt[`AUX_PIN_COUNT-1:0] = pin_level;
                    `OFS_MAIN_QUERY:  prdata_nxt[`QUERY_W-1:0]       = main_query_r;
                    `OFS_MAIN_RESULT: prdata_nxt                     = main_result_r;
                    default:          prdata_nxt                     = '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign apb_rsp.prdata  = prdata_r;
    assign apb_rsp.pready  = pready_r;
    assign apb_rsp.pslverr = pslverr_r;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // this bank's own register set
    always_comb begin
        pin_select_nxt = pin_select_r;
        pullup_dis_nxt = pullup_dis_r;
        data_nxt       = data_r;
        dir_nxt        = dir_r;
        gpio_en_nxt    = gpio_en_r;
        main_query_nxt = main_query_r;
        if (apb_write) begin
            unique case (addr)
                // reserved codes are stored as written and read back
                `OFS_PIN_SELECT: pin_select_nxt = wdata[`AUX_SEL_W-1:0];
                `OFS_PULLUP_DIS: pullup_dis_nxt = wdata[`AUX_PIN_COUNT-1:0];
                `OFS_DATA:       data_nxt       = wdata[`AUX_PIN_COUNT-1:0];
                `OFS_DIR:        dir_nxt        = wdata[`AUX_PIN_COUNT-1:0];
                `OFS_GPIO_EN:    gpio_en_nxt    = wdata[`AUX_PIN_COUNT-1:0];
                `OFS_MAIN_QUERY: main_query_nxt = wdata[`QUERY_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_select_r  <= `RST_PIN_SELECT;
            pullup_dis_r  <= `RST_PULLUP_DIS;
            data_r        <= `RST_DATA;
            dir_r         <= `RST_DIR;
            gpio_en_r     <= `RST_GPIO_EN;
            main_query_r  <= `RST_MAIN_QUERY;
            main_result_r <= '0;
        end else begin
            pin_select_r  <= pin_select_nxt;
            pullup_dis_r  <= pullup_dis_nxt;
            data_r        <= data_nxt;
            dir_r         <= dir_nxt;
            gpio_en_r     <= gpio_en_nxt;
            main_query_r  <= main_query_nxt;
            main_result_r <= main_result_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pin multiplexer
    // ----------------------------------------------------------------
    // pin outputs are registered: one cycle of latency bought glitch-free pins
    always_comb begin
        drive_nxt  = '0;
        mode_n     = pin_mux_pkg::MODE_GPIO;
        comp_src_n = `COMP_NONE;
        for (int n = 0; n < `AUX_PIN_COUNT; n++) begin
            // field of pin n at bits 2n+1..2n
            mode_n     = pin_mode(pin_select_r, n);
            comp_src_n = comp_source(n);
            // each pullup follows its own bit
            drive_nxt.pullup_en[n] = !pullup_dis_r[n];
            unique case (mode_n)
                // mode 0 is the pin's own gpio
                pin_mux_pkg::MODE_GPIO: begin
                    // gpio only once software enables it
                    if (gpio_en_r[n]) begin
                        drive_nxt.level[n]  = data_r[n];
                        drive_nxt.enable[n] = dir_r[n];
                    end
                end
                // comparator map, pins 0 and 6 have none
                pin_mux_pkg::MODE_ALT: begin
                    if (comp_src_n != `COMP_NONE) begin
                        drive_nxt.level[n]  = comp_level[comp_src_n - `COMP_FIRST];
                        drive_nxt.enable[n] = 1'b1;
                    end
                end
                // reserved modes leave the pin undriven
                // software is expected to avoid these codes
                pin_mux_pkg::MODE_RSVD1, pin_mux_pkg::MODE_RSVD2: begin
                    drive_nxt.level[n]  = 1'b0;
                    drive_nxt.enable[n] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // no pin driven, pullups off while analog
            drive_r.level     <= `RST_PIN_BYTE;
            drive_r.enable    <= `RST_PIN_BYTE;
            drive_r.pullup_en <= ~`RST_PULLUP_DIS;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    assign aux_pin_drive = drive_r;

endmodule : comparator_gpio_pin_mux

`default_nettype wire

//--- logic/level_sync3.sv
// three-stage synchroniser that passes a level once two stages agree
`timescale 1ns/1ps
`default_nettype none

module level_sync3 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // asynchronous levels in, settled levels out
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // a bit only moves when stage two and three agree, filtering one-cycle glitches
    always_comb begin
        out_nxt = out_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                out_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            out_r <= '0;
        end else begin
            s1_r  <= async_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign level_out = out_r;

endmodule : level_sync3

`default_nettype wire

//--- logic/main_bank_func_table.sv
// function lookup for main bank pins 40 to 71 by peripheral mode
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"

module main_bank_func_table (
    // lookup key
    input  wire logic [`MAIN_PIN_W-1:0]  pin_num,
    input  wire pin_mux_pkg::aux_mode_t  mode,
    // lookup answer
    output var  pin_mux_pkg::main_func_t func,
    output var  logic                    present
);

    // the table is pure wiring; the top registers its answer
    always_comb begin
        func    = pin_mux_pkg::FN_NONE;
        present = 1'b0;
        if (pin_num >= 7'h28 && pin_num <= 7'h47) begin
            present = 1'b1;
        end
        // positions 44 and 64 to 67 are bonded to nothing
        if (pin_num == 7'h2c || (pin_num >= 7'h40 && pin_num <= 7'h43)) begin
            present = 1'b0;
        end
        if (present) begin
            unique case (mode)
                pin_mux_pkg::MODE_GPIO: begin
                    func = pin_mux_pkg::FN_GPIO;
                end
                pin_mux_pkg::MODE_RSVD1: begin
                    unique case (pin_num)
                        7'h30:   func = pin_mux_pkg::FN_CAPTURE_5;
                        7'h31:   func = pin_mux_pkg::FN_CAPTURE_6;
                        7'h32:   func = pin_mux_pkg::FN_QEP1_A;
                        7'h33:   func = pin_mux_pkg::FN_QEP1_B;
                        7'h34:   func = pin_mux_pkg::FN_QEP1_STROBE;
                        7'h35:   func = pin_mux_pkg::FN_QEP1_INDEX;
                        7'h36:   func = pin_mux_pkg::FN_SPI_MOSI;
                        7'h37:   func = pin_mux_pkg::FN_SPI_MISO;
                        7'h38:   func = pin_mux_pkg::FN_SPI_CLK;
                        7'h39:   func = pin_mux_pkg::FN_SPI_SEL;
                        7'h3a:   func = pin_mux_pkg::FN_SPORT_RX_CLK;
                        7'h3b:   func = pin_mux_pkg::FN_SPORT_RX_FRAME;
                        default: func = pin_mux_pkg::FN_NONE;
                    endcase
                end
                pin_mux_pkg::MODE_RSVD2: begin
                    func = pin_mux_pkg::FN_NONE;
                end
                pin_mux_pkg::MODE_ALT: begin
                    unique case (pin_num)
                        7'h36:   func = pin_mux_pkg::FN_QEP3_A;
                        7'h37:   func = pin_mux_pkg::FN_QEP3_B;
                        7'h38:   func = pin_mux_pkg::FN_QEP3_STROBE;
                        7'h39:   func = pin_mux_pkg::FN_QEP3_INDEX;
                        7'h3a:   func = pin_mux_pkg::FN_PWM7_A;
                        7'h3b:   func = pin_mux_pkg::FN_PWM7_B;
                        7'h3c:   func = pin_mux_pkg::FN_PWM8_A;
                        7'h3d:   func = pin_mux_pkg::FN_PWM8_B;
                        7'h3e:   func = pin_mux_pkg::FN_PWM9_A;
                        7'h3f:   func = pin_mux_pkg::FN_PWM9_B;
                        default: func = pin_mux_pkg::FN_NONE;
                    endcase
                end
            endcase
        end
    end

endmodule : main_bank_func_table

`default_nettype wire

//--- logic/pin_mux_defs.svh
// constants for the comparator and gpio auxiliary pin multiplexer
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define AUX_PIN_COUNT      8
`define AUX_COMP_COUNT     6
`define AUX_SEL_W          16
`define APB_ADDR_W         12
`define APB_DATA_W         32
`define MAIN_PIN_W         7
`define COMP_IDX_W         3
`define COMP_NONE          3'h0
`define COMP_FIRST         3'h1

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_PIN_SELECT     12'h000
`define OFS_PULLUP_DIS     12'h004
`define OFS_DATA           12'h008
`define OFS_DIR            12'h00c
`define OFS_GPIO_EN        12'h010
`define OFS_PIN_LEVEL      12'h014
`define OFS_MAIN_QUERY     12'h018
`define OFS_MAIN_RESULT    12'h01c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PIN_SELECT     16'h0000
`define RST_PULLUP_DIS     8'hff
`define RST_DATA           8'h00
`define RST_DIR            8'h00
`define RST_GPIO_EN        8'h00
`define RST_MAIN_QUERY     10'h000
`define RST_PIN_BYTE       8'h00
`define RST_COMP_BITS      6'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define QUERY_W            10
`define QUERY_PIN_LSB      0
`define QUERY_PIN_MSB      6
`define QUERY_MODE_LSB     8
`define QUERY_MODE_MSB     9
`define RESULT_FUNC_MSB    4
`define RESULT_PRESENT_BIT 8

`endif

//--- logic/pin_mux_pkg.sv
// types shared by the auxiliary pin multiplexer files
`include "pin_mux_defs.svh"

package pin_mux_pkg;

    // ----------------------------------------------------------------
    // pin modes and main bank functions
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_GPIO  = 2'h0,
        MODE_RSVD1 = 2'h1,
        MODE_RSVD2 = 2'h2,
        MODE_ALT   = 2'h3
    } aux_mode_t;

    typedef enum logic [4:0] {
        FN_NONE, FN_GPIO, FN_CAPTURE_5, FN_CAPTURE_6,
        FN_QEP1_A, FN_QEP1_B, FN_QEP1_STROBE, FN_QEP1_INDEX,
        FN_SPI_MOSI, FN_SPI_MISO, FN_SPI_CLK, FN_SPI_SEL,
        FN_SPORT_RX_CLK, FN_SPORT_RX_FRAME,
        FN_QEP3_A, FN_QEP3_B, FN_QEP3_STROBE, FN_QEP3_INDEX,
        FN_PWM7_A, FN_PWM7_B, FN_PWM8_A, FN_PWM8_B, FN_PWM9_A, FN_PWM9_B
    } main_func_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                      psel;
        logic                      penable;
        logic                      pwrite;
        logic [`APB_ADDR_W-1:0]    paddr;
        logic [`APB_DATA_W-1:0]    pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [`APB_DATA_W-1:0]    prdata;
        logic                      pready;
        logic                      pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [`AUX_PIN_COUNT-1:0] level;
        logic [`AUX_PIN_COUNT-1:0] enable;
        logic [`AUX_PIN_COUNT-1:0] pullup_en;
    } pin_drive_t;

endpackage : pin_mux_pkg
